//--- hw/cal_seq_defs.vh
// constants for the calibration command sequencer
`ifndef CAL_SEQ_DEFS_VH
`define CAL_SEQ_DEFS_VH
// command codes delivered by the frame parser
`define CMD_CAL_BEGIN_DONE 4'h0
`define CMD_CAL_ESCAPE     4'h1
`define CMD_POLY_OPEN      4'h2
`define CMD_POLY_COEF      4'h3
`define CMD_POLY_CLOSE     4'h4
`define CMD_MVV5_START     4'h5
`define CMD_MVV_MASS       4'h6
`define CMD_MVV_VOLT       4'h7
`define CMD_MASS_MODE      4'h8
`define CMD_MASS_POINT     4'h9
`define CMD_SHUNT_CAL      4'ha
`define CMD_ENC_VIEW       4'hb
`define CMD_ENC_SET        4'hc
`define CMD_OTHER_CAL      4'hd
`define CMD_NON_CAL        4'he
// acknowledgment codes
`define ACK_OK             4'h0
`define ACK_REJECT         4'h1
`define ACK_PROMPT         4'h2
`define ACK_READING        4'h3
`define ACK_DONE           4'h4
`define ACK_CANCEL         4'h5
`define ACK_ENCODER        4'h6
// calibration methods reported on commit
`define METH_POLY          2'h0
`define METH_MVV5          2'h1
`define METH_MASS          2'h2
`define METH_SHUNT         2'h3
// limits and staging slots
`define MAX_DEGREE         3'h5
`define MVV_POINTS         3'h5
`define SLOT_VOLT_BASE     4'h5
`define SLOT_SHUNT_FACTOR  4'ha
`define SLOT_SHUNT_READ    4'hb
// reading window: time in ms and clock rate in kHz
`define READ_TIME_MS       10000
`define CLK_KHZ            50000
`define READ_CYCLES        (`READ_TIME_MS * `CLK_KHZ)
`define SAMPLE_SHIFT       6
`define ENC_CPI_RESET      32'h00005dc0
`endif

//--- hw/load_cell_cal_command_sequencer.v
// sequencer for remote calibration subcommands of a force indicator
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] polynomial opening accepted only inside an open calibration session
// [RULE_02] polynomial degree must be 0..5, otherwise rejected
// [RULE_03] coefficient entry carries index 0..5 and its value
// [RULE_04] coefficients in ascending order from zero; after last, prompt for closing command
// [RULE_05] closing polynomial command starts 10 s shunt reading, then reports completion
// [RULE_06] mass/mV-per-V entries need session and five-point start accepted
// [RULE_07] mass then mV-per-V per point, alternating up to point five
// [RULE_08] after point five, mass entry index 0 finishes with shunt check
// [RULE_09] escape abandons session, calibration data left untouched
// [RULE_10] mass mode selects two- or five-point, then prompts point 1
// [RULE_11] mass points need session and mass mode accepted
// [RULE_12] each mass point averages 10 s of load cell readings
// [RULE_13] point n+1 only after point n finished; prompt next point
// [RULE_14] mass point 0 completes and stores the shunt measurement
// [RULE_15] shunt factor command acts only within a session
// [RULE_16] encoder view returns stored counts-per-inch constant
// [RULE_17] encoder set replaces the constant and acknowledges new value
// [RULE_18] non-calibration command during a session cancels it
// [RULE_19] commands need our address; acknowledgments carry our address
// [RULE_20] out-of-sequence command leaves state unchanged, nothing calibrated
`include "cal_seq_defs.vh"
module load_cell_cal_command_sequencer #(
   parameter READ_CYCLES = `READ_CYCLES
)(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [7:0]  unit_addr,
   input  wire        cmd_valid,
   input  wire [7:0]  cmd_addr,
   input  wire [3:0]  cmd_code,
   input  wire [3:0]  cmd_index,
   input  wire [31:0] cmd_value,
   input  wire [23:0] adc_data,
   input  wire [3:0]  stage_rd_idx,
   output reg         ack_valid,
   output reg  [7:0]  ack_addr,
   output reg  [3:0]  ack_code,
   output reg  [31:0] ack_value,
   output reg         cal_active,
   output reg         reading_busy,
   output reg         cal_commit,
   output reg  [1:0]  cal_method,
   output reg  [2:0]  cal_points,
   output reg  [31:0] enc_cpi,
   output reg  [31:0] stage_rd_data
);
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_POLY  = 6'h02;
   localparam [5:0] ST_MVV   = 6'h04;
   localparam [5:0] ST_MASS  = 6'h08;
   localparam [5:0] ST_READ  = 6'h10;
   localparam [5:0] ST_SHUNT = 6'h20;
   localparam [31:0] TICK_CYCLES = READ_CYCLES >> `SAMPLE_SHIFT;
   localparam [6:0]  NSAMPLES    = 7'h40;

   reg [31:0] stage_mem [0:15];
   reg [5:0]  state_reg;
   reg [2:0]  degree_reg;
   reg [3:0]  next_idx_reg;
   reg        want_volt_reg;
   reg [2:0]  pts_total_reg;
   reg [31:0] tick_reg;
   reg [6:0]  nsamp_reg;
   reg [29:0] sum_reg;
   reg [1:0]  method_reg;

   wire       cmd_ours = cmd_valid && (cmd_addr == unit_addr); // [RULE_19]
   wire       tick     = (tick_reg == TICK_CYCLES - 32'h1);
   wire       win_end  = tick && (nsamp_reg == NSAMPLES - 7'h1);
   wire [29:0] sum_nxt = sum_reg + {6'h00, adc_data};

   // true when the command belongs to the calibration family
   function is_cal;
      input [3:0] code;
      begin
         is_cal = (code != `CMD_NON_CAL);
      end
   endfunction

   // staging read port
   always @(posedge ref_clk)
   begin
      if (rst)
         stage_rd_data <= 32'h00000000;
      else
         stage_rd_data <= stage_mem[stage_rd_idx];
   end

   // command sequencing, reading windows and acknowledgments
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_reg     <= ST_IDLE;
         cal_active    <= 1'b0;
         degree_reg    <= 3'h0;
         next_idx_reg  <= 4'h0;
         want_volt_reg <= 1'b0;
         pts_total_reg <= 3'h0;
         tick_reg      <= 32'h00000000;
         nsamp_reg     <= 7'h00;
         sum_reg       <= 30'h00000000;
         method_reg    <= `METH_POLY;
         ack_valid     <= 1'b0;
         ack_addr      <= 8'h00;
         ack_code      <= `ACK_OK;
         ack_value     <= 32'h00000000;
         reading_busy  <= 1'b0;
         cal_commit    <= 1'b0;
         cal_method    <= `METH_POLY;
         cal_points    <= 3'h0;
         enc_cpi       <= `ENC_CPI_RESET;
      end
      else
      begin
         ack_valid  <= 1'b0;
         cal_commit <= 1'b0;
         ack_addr   <= unit_addr; // [RULE_19]
         // averaging window: one sample per tick, 64 samples in 10 s
         if (state_reg == ST_READ || state_reg == ST_SHUNT)
         begin
            tick_reg <= tick ? 32'h00000000 : tick_reg + 32'h1;
            if (tick)
            begin
               sum_reg   <= sum_nxt;
               nsamp_reg <= nsamp_reg + 7'h1;
            end
         end
         if (cmd_ours && cal_active && !is_cal(cmd_code))
         begin
            // foreign command aborts the session
            state_reg    <= ST_IDLE; // [RULE_18]
            cal_active   <= 1'b0;
            reading_busy <= 1'b0;
            ack_valid    <= 1'b1;
            ack_code     <= `ACK_CANCEL;
            ack_value    <= 32'h00000000;
         end
         else if (cmd_ours && cmd_code == `CMD_CAL_ESCAPE)
         begin
            // staged values are simply never committed
            ack_valid <= 1'b1;
            ack_value <= 32'h00000000;
            if (cal_active)
            begin
               state_reg    <= ST_IDLE; // [RULE_09]
               cal_active   <= 1'b0;
               reading_busy <= 1'b0;
               ack_code     <= `ACK_CANCEL;
            end
            else
            begin
               ack_code  <= `ACK_REJECT; // [RULE_20]
               ack_value <= {28'h0, cmd_code};
            end
         end
         // window completion wins over an encoder command in its last cycle
         else if (cmd_ours && cmd_code == `CMD_ENC_VIEW && !(reading_busy && win_end))
         begin
            ack_valid <= 1'b1;
            ack_code  <= `ACK_ENCODER;
            ack_value <= enc_cpi; // [RULE_16]
         end
         else if (cmd_ours && cmd_code == `CMD_ENC_SET && !(reading_busy && win_end))
         begin
            enc_cpi   <= cmd_value; // [RULE_17]
            ack_valid <= 1'b1;
            ack_code  <= `ACK_ENCODER;
            ack_value <= cmd_value;
         end
         else if (state_reg == ST_READ && win_end)
         begin
            // point reading finished, store the average
            stage_mem[`SLOT_VOLT_BASE + next_idx_reg - 4'h1] <= {8'h00, sum_nxt[29:6]}; // [RULE_12]
            state_reg    <= ST_MASS;
            reading_busy <= 1'b0;
            ack_valid    <= 1'b1;
            ack_code     <= `ACK_PROMPT; // [RULE_13]
            ack_value    <= (next_idx_reg == {1'b0, pts_total_reg}) ? 32'h0 : {28'h0, next_idx_reg + 4'h1};
            next_idx_reg <= next_idx_reg + 4'h1;
         end
         else if (state_reg == ST_SHUNT && win_end)
         begin
            // shunt reading finished: commit and report
            stage_mem[`SLOT_SHUNT_READ] <= {8'h00, sum_nxt[29:6]}; // [RULE_14]
            state_reg    <= ST_IDLE;
            cal_active   <= 1'b0;
            reading_busy <= 1'b0;
            cal_commit   <= 1'b1; // [RULE_05]
            cal_method   <= method_reg;
            cal_points   <= pts_total_reg;
            ack_valid    <= 1'b1;
            ack_code     <= `ACK_DONE;
            ack_value    <= {30'h0, method_reg};
         end
         else if (cmd_ours)
         begin
            // default answer is a refusal with no state change
            ack_valid <= 1'b1;
            ack_code  <= `ACK_REJECT; // [RULE_20]
            ack_value <= {28'h0, cmd_code};
            case (cmd_code)
               `CMD_CAL_BEGIN_DONE:
                  if (state_reg == ST_IDLE)
                  begin
                     cal_active <= 1'b1;
                     ack_code   <= `ACK_OK;
                  end
               `CMD_POLY_OPEN:
                  if (cal_active && state_reg == ST_IDLE // [RULE_01]
                      && cmd_index <= {1'b0, `MAX_DEGREE}) // [RULE_02]
                  begin
                     state_reg    <= ST_POLY;
                     degree_reg   <= cmd_index[2:0];
                     next_idx_reg <= 4'h0;
                     ack_code     <= `ACK_PROMPT;
                     ack_value    <= 32'h0;
                  end
               `CMD_POLY_COEF:
                  if (state_reg == ST_POLY && cmd_index == next_idx_reg
                      && next_idx_reg <= {1'b0, degree_reg}) // [RULE_03]
                  begin
                     stage_mem[cmd_index] <= cmd_value;
                     next_idx_reg <= next_idx_reg + 4'h1; // [RULE_04]
                     ack_code     <= `ACK_PROMPT;
                     ack_value    <= (next_idx_reg == {1'b0, degree_reg}) ? 32'h0 : {28'h0, next_idx_reg + 4'h1};
                  end
               `CMD_POLY_CLOSE:
                  if (state_reg == ST_POLY && next_idx_reg == {1'b0, degree_reg} + 4'h1)
                  begin
                     state_reg     <= ST_SHUNT; // [RULE_05]
                     method_reg    <= `METH_POLY;
                     pts_total_reg <= degree_reg;
                     reading_busy  <= 1'b1;
                     tick_reg      <= 32'h0;
                     nsamp_reg     <= 7'h0;
                     sum_reg       <= 30'h0;
                     ack_code      <= `ACK_READING;
                  end
               `CMD_MVV5_START:
                  if (cal_active && state_reg == ST_IDLE)
                  begin
                     state_reg     <= ST_MVV;
                     next_idx_reg  <= 4'h1;
                     want_volt_reg <= 1'b0;
                     ack_code      <= `ACK_PROMPT;
                     ack_value     <= 32'h1;
                  end
               `CMD_MVV_MASS:
                  if (state_reg == ST_MVV && !want_volt_reg) // [RULE_06]
                  begin
                     if (cmd_index == 4'h0 && next_idx_reg == {1'b0, `MVV_POINTS} + 4'h1)
                     begin
                        state_reg     <= ST_SHUNT; // [RULE_08]
                        method_reg    <= `METH_MVV5;
                        pts_total_reg <= `MVV_POINTS;
                        reading_busy  <= 1'b1;
                        tick_reg      <= 32'h0;
                        nsamp_reg     <= 7'h0;
                        sum_reg       <= 30'h0;
                        ack_code      <= `ACK_READING;
                     end
                     else if (cmd_index == next_idx_reg && cmd_index != 4'h0
                              && next_idx_reg <= {1'b0, `MVV_POINTS})
                     begin
                        stage_mem[cmd_index - 4'h1] <= cmd_value;
                        want_volt_reg <= 1'b1; // [RULE_07]
                        ack_code      <= `ACK_PROMPT;
                        ack_value     <= {28'h0, cmd_index};
                     end
                  end
               `CMD_MVV_VOLT:
                  if (state_reg == ST_MVV && want_volt_reg && cmd_index == next_idx_reg) // [RULE_07]
                  begin
                     stage_mem[`SLOT_VOLT_BASE + cmd_index - 4'h1] <= cmd_value;
                     want_volt_reg <= 1'b0;
                     next_idx_reg  <= next_idx_reg + 4'h1;
                     ack_code      <= `ACK_PROMPT;
                     ack_value     <= (next_idx_reg == {1'b0, `MVV_POINTS}) ? 32'h0 : {28'h0, next_idx_reg + 4'h1};
                  end
               `CMD_MASS_MODE:
                  if (cal_active && state_reg == ST_IDLE && (cmd_index == 4'h2 || cmd_index == 4'h5))
                  begin
                     state_reg     <= ST_MASS; // [RULE_10]
                     pts_total_reg <= cmd_index[2:0];
                     next_idx_reg  <= 4'h1;
                     ack_code      <= `ACK_PROMPT;
                     ack_value     <= 32'h1;
                  end
               `CMD_MASS_POINT:
                  if (state_reg == ST_MASS) // [RULE_11]
                  begin
                     if (cmd_index == 4'h0 && next_idx_reg == {1'b0, pts_total_reg} + 4'h1)
                     begin
                        state_reg    <= ST_SHUNT; // [RULE_14]
                        method_reg   <= `METH_MASS;
                        reading_busy <= 1'b1;
                        tick_reg     <= 32'h0;
                        nsamp_reg    <= 7'h0;
                        sum_reg      <= 30'h0;
                        ack_code     <= `ACK_READING;
                     end
                     else if (cmd_index == next_idx_reg && cmd_index != 4'h0
                              && next_idx_reg <= {1'b0, pts_total_reg}) // [RULE_13]
                     begin
                        stage_mem[cmd_index - 4'h1] <= cmd_value;
                        state_reg    <= ST_READ; // [RULE_12]
                        reading_busy <= 1'b1;
                        tick_reg     <= 32'h0;
                        nsamp_reg    <= 7'h0;
                        sum_reg      <= 30'h0;
                        ack_code     <= `ACK_READING;
                        ack_value    <= {28'h0, cmd_index};
                     end
                  end
               `CMD_SHUNT_CAL:
                  if (cal_active && state_reg == ST_IDLE) // [RULE_15]
                  begin
                     stage_mem[`SLOT_SHUNT_FACTOR] <= cmd_value;
                     state_reg     <= ST_SHUNT;
                     method_reg    <= `METH_SHUNT;
                     pts_total_reg <= 3'h0;
                     reading_busy  <= 1'b1;
                     tick_reg      <= 32'h0;
                     nsamp_reg     <= 7'h0;
                     sum_reg       <= 30'h0;
                     ack_code      <= `ACK_READING;
                  end
               default:
                  ack_code <= `ACK_REJECT;
            endcase
         end
      end
   end
endmodule

//--- testbench/cal_seq_properties.sv
// checker for the calibration command sequencer ports
`timescale 1ns/1ps
`include "cal_seq_defs.vh"
module cal_seq_properties #(
   parameter READ_CYCLES = 640
)(
   input wire        ref_clk,
   input wire        rst,
   input wire [7:0]  unit_addr,
   input wire        cmd_valid,
   input wire [7:0]  cmd_addr,
   input wire [3:0]  cmd_code,
   input wire [3:0]  cmd_index,
   input wire [31:0] cmd_value,
   input wire        ack_valid,
   input wire [7:0]  ack_addr,
   input wire [3:0]  ack_code,
   input wire [31:0] ack_value,
   input wire        cal_active,
   input wire        reading_busy,
   input wire        cal_commit,
   input wire [31:0] enc_cpi
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // command for us while no window runs
   wire        taken = cmd_valid && (cmd_addr == unit_addr) && !reading_busy;
   reg  [15:0] busy_cnt_reg;
   // length of the running averaging window
   always @(posedge ref_clk)
      if (rst || !reading_busy)
         busy_cnt_reg <= 16'h0;
      else
         busy_cnt_reg <= busy_cnt_reg + 16'h1;
   ack_follows_a: assert property (taken |=> ack_valid && ack_addr == unit_addr)
      else $error("no ack after command");
   foreign_silent_a: assert property (cmd_valid && cmd_addr != unit_addr && !reading_busy |=> !ack_valid)
      else $error("ack for foreign address");
   poly_needs_session_a: assert property (taken && !cal_active && cmd_code == `CMD_POLY_OPEN |=> ack_code == `ACK_REJECT)
      else $error("poly opened without session");
   degree_range_a: assert property (taken && cmd_code == `CMD_POLY_OPEN && cmd_index > 4'h5 |=> ack_code == `ACK_REJECT)
      else $error("bad degree accepted");
   reject_value_a: assert property (ack_valid && ack_code == `ACK_REJECT |-> ack_value == {28'h0, $past(cmd_code)})
      else $error("reject value wrong");
   commit_done_a: assert property (cal_commit |-> ack_valid && ack_code == `ACK_DONE && !cal_active)
      else $error("commit without done");
   escape_clean_a: assert property (taken && cmd_code == `CMD_CAL_ESCAPE |=> !cal_active && !cal_commit)
      else $error("escape left session");
   noncal_cancel_a: assert property (taken && cal_active && cmd_code == `CMD_NON_CAL
      |=> ack_code == `ACK_CANCEL && !cal_active)
      else $error("session not cancelled");
   enc_set_a: assert property (taken && cmd_code == `CMD_ENC_SET
      |=> ack_code == `ACK_ENCODER && enc_cpi == $past(cmd_value) && ack_value == $past(cmd_value))
      else $error("encoder constant not set");
   window_len_a: assert property ($fell(reading_busy) && ack_valid && (ack_code == `ACK_PROMPT || ack_code == `ACK_DONE)
      |-> busy_cnt_reg >= READ_CYCLES - 8 && busy_cnt_reg <= READ_CYCLES + 8)
      else $error("window length wrong");
   cover property (cal_commit);
   cover property (ack_valid && ack_code == `ACK_CANCEL);
   cover property (ack_valid && ack_code == `ACK_REJECT);
endmodule
bind load_cell_cal_command_sequencer cal_seq_properties #(.READ_CYCLES(READ_CYCLES)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .unit_addr(unit_addr), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
   .cmd_code(cmd_code), .cmd_index(cmd_index), .cmd_value(cmd_value), .ack_valid(ack_valid),
   .ack_addr(ack_addr), .ack_code(ack_code), .ack_value(ack_value), .cal_active(cal_active),
   .reading_busy(reading_busy), .cal_commit(cal_commit), .enc_cpi(enc_cpi));

//--- testbench/remote_terminal.sv
// remote terminal model sending parsed command frames
`timescale 1ns/1ps
module remote_terminal (
   input  wire        ref_clk,
   output reg         cmd_valid,
   output reg  [7:0]  cmd_addr,
   output reg  [3:0]  cmd_code,
   output reg  [3:0]  cmd_index,
   output reg  [31:0] cmd_value
);
   // one frame per call, index and value scrambled once it is over
   task send(input [7:0] a, input [3:0] c, input [3:0] i, input [31:0] v);
      begin
         @(posedge ref_clk);
         cmd_valid <= 1'b1;
         cmd_addr  <= a;
         cmd_code  <= c;
         cmd_index <= i;
         cmd_value <= v;
         @(posedge ref_clk);
         cmd_valid <= 1'b0;
         cmd_index <= ~i;
         cmd_value <= ~v;
      end
   endtask
   initial
   begin
      cmd_valid = 1'b0;
      cmd_addr  = 8'h00;
      cmd_code  = 4'h0;
      cmd_index = 4'h0;
      cmd_value = 32'h0;
   end
endmodule

//--- testbench/load_cell_cal_command_sequencer_tb.sv
// self-checking bench for the calibration command sequencer
`timescale 1ns/1ps
`include "cal_seq_defs.vh"
module load_cell_cal_command_sequencer_tb;
   reg         ref_clk = 1'b0;
   reg         rst = 1'b1;
   reg  [7:0]  unit_addr = 8'h01;
   reg  [23:0] adc_data = 24'h00abcd;
   reg  [3:0]  stage_rd_idx = 4'h5;
   wire        cmd_valid, ack_valid, cal_active, reading_busy, cal_commit;
   wire [7:0]  cmd_addr, ack_addr;
   wire [3:0]  cmd_code, cmd_index, ack_code;
   wire [31:0] cmd_value, ack_value, enc_cpi, stage_rd_data;
   wire [1:0]  cal_method;
   wire [2:0]  cal_points;
   integer     num_errors = 0;
   integer     n_tests = 0;
   integer     k;
   reg  [3:0]  ac;
   reg  [31:0] av;
   reg         cm;
   always #10 ref_clk = ~ref_clk;
   remote_terminal rt_u (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_code(cmd_code),
      .cmd_index(cmd_index), .cmd_value(cmd_value));
   load_cell_cal_command_sequencer #(.READ_CYCLES(640)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .unit_addr(unit_addr), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_code(cmd_code),
      .cmd_index(cmd_index), .cmd_value(cmd_value), .adc_data(adc_data), .stage_rd_idx(stage_rd_idx),
      .ack_valid(ack_valid), .ack_addr(ack_addr), .ack_code(ack_code), .ack_value(ack_value),
      .cal_active(cal_active), .reading_busy(reading_busy), .cal_commit(cal_commit), .cal_method(cal_method),
      .cal_points(cal_points), .enc_cpi(enc_cpi), .stage_rd_data(stage_rd_data));
   task end_of_test;
      begin
         if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e)
         begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // bounded wait for the next ack pulse
   task wait_ack(input integer lim);
      integer i;
      begin
         i = 0;
         do
         begin
            @(negedge ref_clk);
            i = i + 1;
         end
         while (ack_valid !== 1'b1 && i < lim);
         if (ack_valid !== 1'b1)
         begin
            chk("ack_valid", 32'h1, 32'h0);
            end_of_test;
         end
         ac = ack_code;
         av = ack_value;
         cm = cal_commit;
      end
   endtask
   // send one command, 4'hf or all ones skip a field
   task do_cmd(input [3:0] c, input [3:0] i, input [31:0] v, input [3:0] ec, input [31:0] ev);
      begin
         rt_u.send(unit_addr, c, i, v);
         wait_ack(4);
         if (ec != 4'hf)
            chk("ack_code", {28'h0, ec}, {28'h0, ac});
         if (ev != 32'hffffffff)
            chk("ack_value", ev, av);
      end
   endtask
   // end of the final reading window
   task finish_read(input [1:0] m);
      begin
         wait_ack(800);
         chk("done_code", {28'h0, `ACK_DONE}, {28'h0, ac});
         chk("cal_commit", 32'h1, {31'h0, cm});
         chk("cal_method", {30'h0, m}, {30'h0, cal_method});
         chk("cal_active", 32'h0, {31'h0, cal_active});
      end
   endtask
   task t_encoder;
      begin
         chk("enc_cpi", 32'h00005dc0, enc_cpi);
         do_cmd(`CMD_ENC_VIEW, 4'h0, 32'h0, `ACK_ENCODER, 32'h00005dc0);
         do_cmd(`CMD_ENC_SET, 4'h0, 32'h0000fa00, `ACK_ENCODER, 32'h0000fa00);
         chk("enc_cpi", 32'h0000fa00, enc_cpi);
         rt_u.send(8'h02, `CMD_ENC_VIEW, 4'h0, 32'h0);
         for (k = 0; k < 4; k = k + 1)
         begin
            @(negedge ref_clk);
            chk("foreign_ack", 32'h0, {31'h0, ack_valid});
         end
         chk("ack_addr", {24'h0, unit_addr}, {24'h0, ack_addr});
      end
   endtask
   task t_poly;
      begin
         do_cmd(`CMD_POLY_OPEN, 4'h2, 32'h0, `ACK_REJECT, 32'h2);
         do_cmd(`CMD_CAL_BEGIN_DONE, 4'h0, 32'h0, `ACK_OK, 32'hffffffff);
         do_cmd(`CMD_POLY_OPEN, 4'h6, 32'h0, `ACK_REJECT, 32'h2);
         do_cmd(`CMD_POLY_OPEN, 4'h2, 32'h0, `ACK_PROMPT, 32'h0);
         do_cmd(`CMD_POLY_COEF, 4'h1, 32'h3f00, `ACK_REJECT, 32'h3);
         do_cmd(`CMD_POLY_COEF, 4'h0, 32'h1111, `ACK_PROMPT, 32'h1);
         do_cmd(`CMD_POLY_COEF, 4'h1, 32'h2222, `ACK_PROMPT, 32'h2);
         do_cmd(`CMD_POLY_COEF, 4'h2, 32'h3333, `ACK_PROMPT, 32'h0);
         do_cmd(`CMD_POLY_CLOSE, 4'h0, 32'h0, `ACK_READING, 32'hffffffff);
         finish_read(`METH_POLY);
         chk("cal_points", 32'h2, {29'h0, cal_points});
         @(posedge ref_clk);
         stage_rd_idx <= 4'h2;
         repeat (2) @(negedge ref_clk);
         chk("stage_coef", 32'h3333, stage_rd_data);
         @(posedge ref_clk);
         stage_rd_idx <= 4'h5;
      end
   endtask
   task t_mvv;
      begin
         do_cmd(`CMD_CAL_BEGIN_DONE, 4'h0, 32'h0, `ACK_OK, 32'hffffffff);
         do_cmd(`CMD_MVV_MASS, 4'h1, 32'h10, `ACK_REJECT, 32'h6);
         do_cmd(`CMD_MVV5_START, 4'h5, 32'h0, 4'hf, 32'hffffffff);
         do_cmd(`CMD_MVV_VOLT, 4'h1, 32'h10, `ACK_REJECT, 32'h7);
         for (k = 1; k <= 5; k = k + 1)
         begin
            do_cmd(`CMD_MVV_MASS, k, 32'h100 * k, `ACK_PROMPT, 32'hffffffff);
            do_cmd(`CMD_MVV_VOLT, k, 32'h10 * k, `ACK_PROMPT, 32'hffffffff);
         end
         do_cmd(`CMD_MVV_MASS, 4'h0, 32'h0, `ACK_READING, 32'hffffffff);
         finish_read(`METH_MVV5);
         chk("cal_points", 32'h5, {29'h0, cal_points});
      end
   endtask
   task t_mass;
      begin
         do_cmd(`CMD_CAL_BEGIN_DONE, 4'h0, 32'h0, `ACK_OK, 32'hffffffff);
         do_cmd(`CMD_MASS_POINT, 4'h1, 32'h0, `ACK_REJECT, 32'h9);
         do_cmd(`CMD_MASS_MODE, 4'h2, 32'h0, `ACK_PROMPT, 32'h1);
         do_cmd(`CMD_MASS_POINT, 4'h1, 32'h0, `ACK_READING, 32'h1);
         chk("reading_busy", 32'h1, {31'h0, reading_busy});
         do_cmd(`CMD_MASS_POINT, 4'h2, 32'hc8, `ACK_REJECT, 32'h9);
         wait_ack(800);
         chk("prompt_code", {28'h0, `ACK_PROMPT}, {28'h0, ac});
         chk("prompt_value", 32'h2, av);
         @(negedge ref_clk);
         chk("stage_avg", 32'h0000abcd, stage_rd_data);
         do_cmd(`CMD_MASS_POINT, 4'h2, 32'hc8, `ACK_READING, 32'h2);
         wait_ack(800);
         chk("prompt", {28'h0, `ACK_PROMPT}, {28'h0, ac});
         chk("prompt_last", 32'h0, av);
         do_cmd(`CMD_MASS_POINT, 4'h0, 32'h0, `ACK_READING, 32'hffffffff);
         finish_read(`METH_MASS);
         chk("cal_points", 32'h2, {29'h0, cal_points});
      end
   endtask
   task t_cancel;
      begin
         do_cmd(`CMD_SHUNT_CAL, 4'h0, 32'h140, `ACK_REJECT, 32'ha);
         do_cmd(`CMD_CAL_BEGIN_DONE, 4'h0, 32'h0, `ACK_OK, 32'hffffffff);
         do_cmd(`CMD_NON_CAL, 4'h0, 32'h0, `ACK_CANCEL, 32'hffffffff);
         chk("cal_active", 32'h0, {31'h0, cal_active});
         do_cmd(`CMD_CAL_BEGIN_DONE, 4'h0, 32'h0, `ACK_OK, 32'hffffffff);
         do_cmd(`CMD_MASS_MODE, 4'h5, 32'h0, `ACK_PROMPT, 32'h1);
         do_cmd(`CMD_CAL_ESCAPE, 4'h0, 32'h0, `ACK_CANCEL, 32'hffffffff);
         chk("kept_method", {30'h0, `METH_MASS}, {30'h0, cal_method});
         do_cmd(`CMD_CAL_ESCAPE, 4'h0, 32'h0, `ACK_REJECT, 32'h1);
         do_cmd(`CMD_CAL_BEGIN_DONE, 4'h0, 32'h0, `ACK_OK, 32'hffffffff);
         do_cmd(`CMD_SHUNT_CAL, 4'h0, 32'h140, `ACK_READING, 32'hffffffff);
         finish_read(`METH_SHUNT);
      end
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_encoder;
      t_poly;
      t_mvv;
      t_mass;
      t_cancel;
      end_of_test;
   end
endmodule
